// ===== light_prox_sensor_control.sv
`timescale 1ns/1ps
`include "light_prox_defines.svh"

module light_prox_sensor_control
	import light_prox_pkg::*;
#(
	parameter int STEP_CYCLES = `STEP_CYCLES
) (
	input  wire logic        mclk,
	input  wire logic        rst,
	input  wire logic [4:0]  reg_addr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [7:0]  reg_rdata,
	input  wire logic        sf_strobe,
	input  wire logic [4:0]  sf_code,
	input  wire logic        bus_active,
	input  wire logic [15:0] clear_result,
	input  wire logic [15:0] prox_result,
	output logic             osc_enable,
	output logic             prox_integrate,
	output logic             color_integrate,
	output logic      [15:0] prox_full_scale,
	output logic             irq
);

	// ------------------------------------------------------------------
	// Register storage.
	// ------------------------------------------------------------------
	logic [5:0]  enable_r;         // Enable bits, reserved 7:6 not stored.
	logic [7:0]  color_time_r;     // Colour integration setting.
	logic [7:0]  prox_time_r;      // Proximity integration setting.
	logic [7:0]  wait_time_r;      // Wait duration setting.
	logic [7:0]  thr_r [0:7];      // Threshold bytes, offsets 0x04 to 0x0b.
	logic [7:0]  filter_r;         // Persistence fields.
	logic        wait_extend_r;    // Twelvefold wait stretch.
	logic        prox_irq_flag_r;  // Pending proximity interrupt.
	logic        clear_irq_flag_r; // Pending clear interrupt.
	logic        prox_valid_r;     // Proximity cycle done since enable.
	logic        color_valid_r;    // Colour cycle done since enable.
	logic        bus_s1_r;         // Synchroniser first stage.
	logic        bus_s2_r;         // Synchroniser second stage.

	// Named enable bits.
	wire prox_irq_enable  = enable_r[`BIT_PROX_IRQ_ENABLE];
	wire clear_irq_enable = enable_r[`BIT_CLEAR_IRQ_ENABLE];
	wire wait_on          = enable_r[`BIT_WAIT_ON];
	wire prox_measure_on  = enable_r[`BIT_PROX_MEASURE_ON];
	wire color_measure_on = enable_r[`BIT_COLOR_MEASURE_ON];
	wire oscillator_on    = enable_r[`BIT_OSCILLATOR_ON];

	// Threshold pairs assembled as 16-bit words.
	wire [15:0] clear_low  = {thr_r[1], thr_r[0]};
	wire [15:0] clear_high = {thr_r[3], thr_r[2]};
	wire [15:0] prox_low   = {thr_r[5], thr_r[4]};
	wire [15:0] prox_high  = {thr_r[7], thr_r[6]};
	wire [3:0]  prox_filter_count  = filter_r[7:4];
	wire [3:0]  clear_filter_count = filter_r[3:0];

	// ------------------------------------------------------------------
	// Write decode.
	// ------------------------------------------------------------------
	wire wr_en    = reg_wr && (reg_addr == `OFS_FUNCTION_ENABLE);
	wire wr_ctime = reg_wr && (reg_addr == `OFS_COLOR_INTEG_TIME);
	wire wr_prox_integration_time = reg_wr && (reg_addr == `OFS_PROX_INTEG_TIME);
	wire wr_wait_duration = reg_wr && (reg_addr == `OFS_WAIT_DURATION);
	wire wr_filt  = reg_wr && (reg_addr == `OFS_INTERRUPT_FILTER);
	wire wr_cfg   = reg_wr && (reg_addr == `OFS_CONFIG);

	// Writable registers; the enable register drops reserved bits.
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			enable_r      <= `RST_ENABLE;
			color_time_r  <= `RST_INTEG_TIME;
			prox_time_r   <= `RST_INTEG_TIME;
			wait_time_r   <= `RST_WAIT_DURATION;
			filter_r      <= `RST_BYTE;
			wait_extend_r <= 1'b0;
		end else begin
			if (wr_en)    enable_r      <= reg_wdata[5:0];
			if (wr_ctime) color_time_r  <= reg_wdata;
			if (wr_prox_integration_time) prox_time_r   <= reg_wdata;
			if (wr_wait_duration) wait_time_r   <= reg_wdata;
			if (wr_filt)  filter_r      <= reg_wdata;
			if (wr_cfg)   wait_extend_r <= reg_wdata[`BIT_WAIT_EXTEND];
		end
	end

	// Threshold bytes, one generated flop per offset.
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_thr
			wire wr_thr = reg_wr && (reg_addr == (`OFS_CLEAR_LOW_LO + 5'(gi)));
			always_ff @(posedge mclk or posedge rst) begin
				if (rst) thr_r[gi] <= `RST_BYTE;
				else if (wr_thr) thr_r[gi] <= reg_wdata;
			end
		end
	endgenerate

	// ------------------------------------------------------------------
	// Read path.
	// ------------------------------------------------------------------
	wire [7:0] status_val = {2'b00, prox_irq_flag_r, clear_irq_flag_r,
		2'b00, prox_valid_r, color_valid_r};
	wire is_thr = (reg_addr >= `OFS_CLEAR_LOW_LO) && (reg_addr <= `OFS_PROX_HIGH_HI);
	wire [2:0] thr_idx = 3'(reg_addr - `OFS_CLEAR_LOW_LO);
	logic [7:0] rd_val;

	// Read mux; unmapped offsets read zero.
	always_comb begin
		if (reg_addr == `OFS_FUNCTION_ENABLE)       rd_val = {2'b00, enable_r};
		else if (reg_addr == `OFS_COLOR_INTEG_TIME) rd_val = color_time_r;
		else if (reg_addr == `OFS_PROX_INTEG_TIME)  rd_val = prox_time_r;
		else if (reg_addr == `OFS_WAIT_DURATION)    rd_val = wait_time_r;
		else if (is_thr)                            rd_val = thr_r[thr_idx];
		else if (reg_addr == `OFS_INTERRUPT_FILTER) rd_val = filter_r;
		else if (reg_addr == `OFS_CONFIG)           rd_val = {6'h00, wait_extend_r, 1'b0};
		else if (reg_addr == `OFS_STATUS)           rd_val = status_val;
		else                                        rd_val = 8'h00;
	end

	// Read data is captured the edge a read is strobed.
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) reg_rdata <= 8'h00;
		else if (reg_rd) reg_rdata <= rd_val;
	end

	// ------------------------------------------------------------------
	// Oscillator gating.
	// ------------------------------------------------------------------
	// Bus activity comes from the pin domain and is synchronised first.
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			bus_s1_r   <= 1'b0;
			bus_s2_r   <= 1'b0;
			osc_enable <= 1'b0;
		end else begin
			bus_s1_r   <= bus_active;
			bus_s2_r   <= bus_s1_r;
			osc_enable <= oscillator_on | bus_s2_r;
		end
	end

	// ------------------------------------------------------------------
	// Step timer and phase sequencer.
	// ------------------------------------------------------------------
	localparam int SW = $clog2(STEP_CYCLES + 1);
	phase_t      state_r, state_nxt;
	logic [SW-1:0] tick_cnt_r;  // Oscillator cycles within one step.
	logic [7:0]  steps_r;       // Remaining steps minus one.
	logic [3:0]  wsub_r;        // Sub-steps of a long wait step.
	logic [7:0]  steps_load;

	wire meas_on   = prox_measure_on | color_measure_on;
	wire step_tick = osc_enable && (state_r != PH_IDLE)
		&& (tick_cnt_r == SW'(STEP_CYCLES - 1));
	// A long wait step needs twelve base steps.
	wire wait_step = (state_r != PH_WAIT) || !wait_extend_r
		|| (wsub_r == `WAIT_LONG_FACTOR - 4'd1);
	wire phase_end = step_tick && wait_step && (steps_r == 8'h00);

	// Next phase: proximity, then colour, then the optional wait.
	always_comb begin
		state_nxt  = state_r;
		steps_load = 8'h00;
		case (state_r)
			PH_IDLE: begin
				if (osc_enable && prox_measure_on) state_nxt = PH_PROX;
				else if (osc_enable && color_measure_on) state_nxt = PH_COLOR;
			end
			PH_PROX: begin
				if (phase_end) state_nxt = color_measure_on ? PH_COLOR
					: (wait_on ? PH_WAIT : PH_IDLE);
			end
			PH_COLOR: begin
				if (phase_end) state_nxt = wait_on ? PH_WAIT : PH_IDLE;
			end
			PH_WAIT: begin
				if (phase_end) state_nxt = PH_IDLE;
			end
			default: state_nxt = PH_IDLE;
		endcase
		if (!meas_on) state_nxt = PH_IDLE;
		// 256 minus setting steps, held as count minus one.
		case (state_nxt)
			PH_PROX:  steps_load = ~prox_time_r;
			PH_COLOR: steps_load = ~color_time_r;
			PH_WAIT:  steps_load = ~wait_time_r;
			default:  steps_load = 8'h00;
		endcase
	end

	// Sequencer registers; timers advance only while the oscillator runs.
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			state_r    <= PH_IDLE;
			tick_cnt_r <= '0;
			steps_r    <= 8'h00;
			wsub_r     <= 4'd0;
		end else begin
			state_r <= state_nxt;
			if (state_nxt != state_r) begin
				tick_cnt_r <= '0;
				steps_r    <= steps_load;
				wsub_r     <= 4'd0;
			end else if (osc_enable && state_r != PH_IDLE) begin
				tick_cnt_r <= step_tick ? '0 : tick_cnt_r + SW'(1);
				if (step_tick && wait_step) steps_r <= steps_r - 8'h01;
				if (step_tick) wsub_r <= wait_step ? 4'd0 : wsub_r + 4'd1;
			end
		end
	end

	assign prox_integrate  = (state_r == PH_PROX);
	assign color_integrate = (state_r == PH_COLOR);

	// ------------------------------------------------------------------
	// Result qualification and persistence.
	// ------------------------------------------------------------------
	wire [7:0]  pt_inv    = ~prox_time_r;
	wire [15:0] prox_full = (pt_inv >= 8'h40) ? `PROX_FULL_MAX
		: {pt_inv[5:0], 10'h3ff};
	wire [15:0] prox_sat  = (prox_result > prox_full_scale) ? prox_full_scale : prox_result;
	wire prox_out  = (prox_sat < prox_low) || (prox_sat > prox_high);
	wire clear_out = (clear_result < clear_low) || (clear_result > clear_high);
	wire prox_done  = (state_r == PH_PROX) && phase_end;
	wire color_done = (state_r == PH_COLOR) && phase_end;

	logic [5:0] prox_interrupt_filter_r, clear_interrupt_filter_r; // Consecutive out-of-range counts.
	wire  [5:0] prox_need  = {2'b00, prox_filter_count};
	wire  [5:0] clear_need = (clear_filter_count < 4'd4) ? {2'b00, clear_filter_count}
		: 6'(({2'b00, clear_filter_count} - 6'd3) * 6'd5);
	wire [5:0] prox_run  = prox_out ? prox_interrupt_filter_r + 6'd1 : 6'd0;
	wire [5:0] clear_run = clear_out ? clear_interrupt_filter_r + 6'd1 : 6'd0;
	wire prox_set  = prox_done && ((prox_need == 6'd0)
		|| (prox_out && prox_run >= prox_need));
	wire clear_set = color_done && ((clear_need == 6'd0)
		|| (clear_out && clear_run >= clear_need));
	wire sf_prox  = sf_strobe && (sf_code == `SF_CLR_PROX || sf_code == `SF_CLR_BOTH);
	wire sf_clear = sf_strobe && (sf_code == `SF_CLR_CLEAR || sf_code == `SF_CLR_BOTH);

	// Filter counters saturate at 60; flags give set priority over clear.
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			prox_interrupt_filter_r      <= 6'd0;
			clear_interrupt_filter_r     <= 6'd0;
			prox_irq_flag_r  <= 1'b0;
			clear_irq_flag_r <= 1'b0;
			prox_full_scale  <= 16'h0000;
		end else begin
			prox_full_scale <= prox_full;
			if (prox_done)  prox_interrupt_filter_r  <= (prox_run > 6'd60) ? 6'd60 : prox_run;
			if (color_done) clear_interrupt_filter_r <= (clear_run > 6'd60) ? 6'd60 : clear_run;
			if (prox_set)       prox_irq_flag_r <= 1'b1;
			else if (sf_prox)   prox_irq_flag_r <= 1'b0;
			if (clear_set)      clear_irq_flag_r <= 1'b1;
			else if (sf_clear)  clear_irq_flag_r <= 1'b0;
		end
	end

	// Valid bits mark a completed cycle since the function was enabled.
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			prox_valid_r  <= 1'b0;
			color_valid_r <= 1'b0;
			irq           <= 1'b0;
		end else begin
			prox_valid_r  <= prox_measure_on && (prox_valid_r || prox_done);
			color_valid_r <= color_measure_on && (color_valid_r || color_done);
			irq <= (prox_irq_flag_r && prox_irq_enable)
				|| (clear_irq_flag_r && clear_irq_enable);
		end
	end

	// ------------------------------------------------------------------
	// Assertions.
	// ------------------------------------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	sequence prox_clear_cmd_s;
		sf_prox && !prox_set;
	endsequence
	sequence bus_seen_s;
		bus_active ##1 bus_active ##1 bus_active;
	endsequence

	irq_follows_a: assert property (irq == $past((prox_irq_flag_r && prox_irq_enable)
		|| (clear_irq_flag_r && clear_irq_enable))) else $error("irq mismatch");
	prox_gate_a: assert property (irq && !$past(clear_irq_flag_r && clear_irq_enable)
		|-> $past(prox_irq_enable)) else $error("prox irq without enable");
	clear_gate_a: assert property (irq && !$past(prox_irq_flag_r && prox_irq_enable)
		|-> $past(clear_irq_enable)) else $error("clear irq without enable");
	osc_bus_a: assert property (bus_seen_s |=> osc_enable)
		else $error("oscillator not forced on by bus");
	osc_off_a: assert property (!oscillator_on && !bus_s2_r |=> !osc_enable)
		else $error("oscillator running while off");
	prox_clr_a: assert property (prox_clear_cmd_s |=> !prox_irq_flag_r)
		else $error("proximity flag not cleared");
	set_wins_a: assert property (prox_set
		|=> prox_irq_flag_r ##1 (prox_irq_flag_r || $past(sf_prox)))
		else $error("proximity event lost");
	prox_load_a: assert property (state_r != PH_PROX && state_nxt == PH_PROX
		|=> steps_r == $past(~prox_time_r)) else $error("proximity step count wrong");
	color_load_a: assert property (state_r != PH_COLOR && state_nxt == PH_COLOR
		|=> steps_r == $past(~color_time_r)) else $error("colour step count wrong");
	full_scale_a: assert property (prox_time_r == 8'hff |=> prox_full_scale == 16'h03ff)
		else $error("proximity full scale wrong");
	status_rd_a: assert property (reg_rd && reg_addr == `OFS_STATUS
		|=> reg_rdata[5:4] == $past({prox_irq_flag_r, clear_irq_flag_r}))
		else $error("status flags misread");

	// Pending flags hold until a special-function clear names them.
	prox_hold_a: assert property (prox_irq_flag_r && !sf_prox |=> prox_irq_flag_r)
		else $error("proximity flag dropped");
	clear_hold_a: assert property (clear_irq_flag_r && !sf_clear |=> clear_irq_flag_r)
		else $error("clear flag dropped");
	clear_clr_a: assert property (sf_clear && !clear_set |=> !clear_irq_flag_r)
		else $error("clear flag not cleared");

	// With both interrupt enables low the pin must stay inactive.
	irq_masked_a: assert property (!prox_irq_enable && !clear_irq_enable |=> !irq)
		else $error("irq without any enable");

	// A zero persistence field flags every completed cycle.
	prox_every_a: assert property (prox_done && prox_filter_count == 4'h0
		|=> prox_irq_flag_r) else $error("proximity cycle not flagged");
	clear_every_a: assert property (color_done && clear_filter_count == 4'h0
		|=> clear_irq_flag_r) else $error("colour cycle not flagged");

	// The wait phase loads its own step count.
	wait_load_a: assert property (state_r != PH_WAIT && state_nxt == PH_WAIT
		|=> steps_r == $past(~wait_time_r)) else $error("wait step count wrong");

	// Clearing both measurement bits returns the sequencer to idle.
	idle_off_a: assert property (!meas_on |=> state_r == PH_IDLE)
		else $error("sequencer running with measurements off");

	// Timers stand still while the oscillator is stopped.
	timer_hold_a: assert property (!osc_enable && state_nxt == state_r
		|=> $stable(tick_cnt_r)) else $error("step timer ran without oscillator");

endmodule : light_prox_sensor_control

// ===== light_prox_defines.svh
`ifndef LIGHT_PROX_DEFINES_SVH
`define LIGHT_PROX_DEFINES_SVH

// ----------------------------------------------------------------------
// Register offsets.
// ----------------------------------------------------------------------
`define OFS_FUNCTION_ENABLE   5'h00
`define OFS_COLOR_INTEG_TIME  5'h01
`define OFS_PROX_INTEG_TIME   5'h02
`define OFS_WAIT_DURATION     5'h03
`define OFS_CLEAR_LOW_LO      5'h04
`define OFS_CLEAR_LOW_HI      5'h05
`define OFS_CLEAR_HIGH_LO     5'h06
`define OFS_CLEAR_HIGH_HI     5'h07
`define OFS_PROX_LOW_LO       5'h08
`define OFS_PROX_LOW_HI       5'h09
`define OFS_PROX_HIGH_LO      5'h0a
`define OFS_PROX_HIGH_HI      5'h0b
`define OFS_INTERRUPT_FILTER  5'h0c
`define OFS_CONFIG            5'h0d
`define OFS_STATUS            5'h13

// ----------------------------------------------------------------------
// Field positions and reset values.
// ----------------------------------------------------------------------
`define BIT_PROX_IRQ_ENABLE   5
`define BIT_CLEAR_IRQ_ENABLE  4
`define BIT_WAIT_ON           3
`define BIT_PROX_MEASURE_ON   2
`define BIT_COLOR_MEASURE_ON  1
`define BIT_OSCILLATOR_ON     0
`define BIT_WAIT_EXTEND       1
`define BIT_STAT_PROX_FLAG    5
`define BIT_STAT_CLEAR_FLAG   4
`define BIT_STAT_PROX_VALID   1
`define BIT_STAT_COLOR_VALID  0
`define RST_ENABLE            6'h00
`define RST_INTEG_TIME        8'hff
`define RST_WAIT_DURATION     8'hff
`define RST_BYTE              8'h00

// ----------------------------------------------------------------------
// Special-function codes and timing.
// ----------------------------------------------------------------------
`define SF_CLR_PROX           5'h05
`define SF_CLR_CLEAR          5'h06
`define SF_CLR_BOTH           5'h07
`define STEP_TIME_NS          2400000
`define MCLK_PERIOD_NS        4
`define STEP_CYCLES           (`STEP_TIME_NS / `MCLK_PERIOD_NS)
`define WAIT_LONG_FACTOR      4'd12
`define PROX_FULL_MAX         16'hffff

`endif

// ===== light_prox_pkg.sv
package light_prox_pkg;

	// Measurement cycle phases of the sequencer.
	typedef enum logic [1:0] {
		PH_IDLE  = 2'b00,
		PH_PROX  = 2'b01,
		PH_COLOR = 2'b10,
		PH_WAIT  = 2'b11
	} phase_t;

endpackage : light_prox_pkg

// ===== adc_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// Analog front end model.
// ----------------------------------------------------------------------
// A channel shows its count only while it integrates; otherwise it toggles.
module adc_model (
	input  wire logic        mclk,
	input  wire logic        prox_integrate,
	input  wire logic        color_integrate,
	input  wire logic [15:0] prox_val,
	input  wire logic [15:0] clear_val,
	output logic      [15:0] prox_result,
	output logic      [15:0] clear_result
);
	// Start from a known count so the toggling pattern is defined.
	initial begin
		prox_result = 16'h0000;
		clear_result = 16'h0000;
	end
	// A held stale count would hide a sample taken at the wrong moment.
	always @(posedge mclk) begin
		prox_result <= #1 prox_integrate ? prox_val : ~prox_result;
		clear_result <= #1 color_integrate ? clear_val : ~clear_result;
	end
endmodule : adc_model

// ===== tb_light_prox_sensor_control.sv
`timescale 1ns/1ps
`include "light_prox_defines.svh"
module tb_light_prox_sensor_control;
	import light_prox_pkg::*;
	localparam int STEP = 8;            // Shortened step length.
	logic        mclk = 0, rst = 1;     // Clock and reset.
	logic        reg_wr = 0, reg_rd = 0, sf_strobe = 0, bus_active = 0, sel = 0;
	logic [4:0]  reg_addr = 0, sf_code = 0;
	logic [7:0]  reg_wdata = 0, reg_rdata, rdv;
	logic [15:0] prox_val = 0, clear_val = 0, clear_result, prox_result, prox_full_scale;
	logic        osc_enable, prox_integrate, color_integrate, irq;
	int          mismatches = 0, checks_done = 0, n, len, k;
	byte unsigned pf [8] = '{0, 1, 2, 15, 1, 3, 4, 15};
	int          pe [8] = '{1, 1, 2, 15, 1, 3, 5, 60};
	wire         cur = sel ? color_integrate : prox_integrate;  // Watched phase.
	// Clock of 4 ns.
	always #2 mclk = ~mclk;
	light_prox_sensor_control #(.STEP_CYCLES(STEP)) dut (.mclk(mclk), .rst(rst),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .sf_strobe(sf_strobe), .sf_code(sf_code),
		.bus_active(bus_active), .clear_result(clear_result), .prox_result(prox_result),
		.osc_enable(osc_enable), .prox_integrate(prox_integrate),
		.color_integrate(color_integrate), .prox_full_scale(prox_full_scale), .irq(irq));
	adc_model afe (.mclk(mclk), .prox_integrate(prox_integrate),
		.color_integrate(color_integrate), .prox_val(prox_val), .clear_val(clear_val),
		.prox_result(prox_result), .clear_result(clear_result));
	// ----------------------------------------------------------------------
	// Tasks.
	// ----------------------------------------------------------------------
	task end_sim();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : end_sim
	task chk(input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			mismatches++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task tick();
		@(posedge mclk);
		#1;
	endtask : tick
	task wr(input logic [4:0] a, input logic [7:0] d);
		tick();
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1;
		tick();
		reg_wr = 0;
	endtask : wr
	task rdchk(input logic [4:0] a, input logic [7:0] exp);
		tick();
		reg_addr = a;
		reg_rd = 1;
		tick();
		reg_rd = 0;
		rdv = reg_rdata;
		chk(rdv, exp);
	endtask : rdchk
	task sfc(input logic [4:0] c);
		tick();
		sf_code = c;
		sf_strobe = 1;
		tick();
		sf_strobe = 0;
		repeat (2) tick();
	endtask : sfc
	// Waits for the watched phase to start, then counts its cycles.
	task count_high();
		n = 0;
		len = 0;
		while (cur !== 1'b1 && n < 4000) begin
			tick();
			n++;
		end
		while (cur === 1'b1 && len < 4000) begin
			tick();
			len++;
		end
	endtask : count_high
	// Counts idle cycles between the end of one phase and the next start.
	task gap();
		count_high();
		len = 0;
		while (cur !== 1'b1 && len < 4000) begin
			tick();
			len++;
		end
	endtask : gap
	// Counts phase ends from a flag clear until the pin rises.
	task interrupt_filter_run(input logic s, input logic [3:0] f, input logic oor, input int exp);
		sel = s;
		wr(`OFS_INTERRUPT_FILTER, s ? {4'h0, f} : {f, 4'h0});
		prox_val = 16'h0180;
		clear_val = 16'h0180;
		wr(`OFS_FUNCTION_ENABLE, s ? 8'h13 : 8'h25);
		count_high();
		if (oor) begin
			prox_val = 16'h0300;
			clear_val = 16'h0050;
		end
		repeat (3) tick();
		sfc(`SF_CLR_BOTH);
		k = 0;
		while (irq !== 1'b1 && k < 80) begin
			count_high();
			repeat (3) tick();
			k++;
		end
		chk(16'(k), 16'(exp));
		wr(`OFS_FUNCTION_ENABLE, 8'h01);
		sfc(`SF_CLR_BOTH);
	endtask : interrupt_filter_run
	// ----------------------------------------------------------------------
	// Tests.
	// ----------------------------------------------------------------------
	// Main sequence of register accesses and phase measurements.
	initial begin
		repeat (2) @(posedge mclk);
		#1 rst = 0;
		rdchk(`OFS_FUNCTION_ENABLE, 8'h00);
		rdchk(`OFS_COLOR_INTEG_TIME, 8'hff);
		rdchk(`OFS_PROX_INTEG_TIME, 8'hff);
		rdchk(`OFS_STATUS, 8'h00);
		chk(prox_full_scale, 16'h03ff);
		wr(`OFS_PROX_INTEG_TIME, 8'hc1);
		tick();
		chk(prox_full_scale, 16'hfbff);
		wr(`OFS_PROX_INTEG_TIME, 8'hbf);
		tick();
		chk(prox_full_scale, 16'hffff);
		wr(`OFS_PROX_INTEG_TIME, 8'hfe);
		tick();
		chk(prox_full_scale, 16'h07ff);
		wr(`OFS_FUNCTION_ENABLE, 8'hff);
		rdchk(`OFS_FUNCTION_ENABLE, 8'h3f);
		wr(`OFS_STATUS, 8'hff);
		rdchk(`OFS_STATUS, 8'h00);
		rdchk(5'h1f, 8'h00);
		wr(`OFS_FUNCTION_ENABLE, 8'h01);
		tick();
		chk(osc_enable, 1);
		wr(`OFS_FUNCTION_ENABLE, 8'h00);
		tick();
		chk(osc_enable, 0);
		bus_active = 1;
		repeat (4) tick();
		chk(osc_enable, 1);
		bus_active = 0;
		repeat (4) tick();
		chk(osc_enable, 0);
		$display("test registers done");
		// Both threshold pairs span 0x0100 to 0x0200.
		for (int i = 0; i < 8; i++)
			wr(5'(`OFS_CLEAR_LOW_LO + i), (i % 4 == 1) ? 8'h01 : (i % 4 == 3) ? 8'h02 : 8'h00);
		rdchk(`OFS_PROX_HIGH_HI, 8'h02);
		wr(`OFS_WAIT_DURATION, 8'hfe);
		prox_val = 16'h0300;
		wr(`OFS_FUNCTION_ENABLE, 8'h25);
		count_high();
		chk(16'(len), 16'(2 * STEP));
		repeat (3) tick();
		chk(irq, 1);
		rdchk(`OFS_STATUS, 8'h22);
		wr(`OFS_FUNCTION_ENABLE, 8'h05);
		repeat (2) tick();
		chk(irq, 0);
		wr(`OFS_FUNCTION_ENABLE, 8'h21);
		repeat (3) tick();
		chk(irq, 1);
		sfc(`SF_CLR_PROX);
		chk(irq, 0);
		rdchk(`OFS_STATUS, 8'h00);
		$display("test proximity done");
		sel = 1;
		clear_val = 16'h0050;
		wr(`OFS_FUNCTION_ENABLE, 8'h13);
		count_high();
		chk(16'(len), 16'(STEP));
		repeat (3) tick();
		chk(irq, 1);
		rdchk(`OFS_STATUS, 8'h11);
		wr(`OFS_FUNCTION_ENABLE, 8'h01);
		repeat (2) tick();
		chk(irq, 0);
		wr(`OFS_FUNCTION_ENABLE, 8'h11);
		repeat (2) tick();
		chk(irq, 1);
		sfc(`SF_CLR_CLEAR);
		chk(irq, 0);
		$display("test clear channel done");
		sel = 0;
		wr(`OFS_FUNCTION_ENABLE, 8'h0d);
		gap();
		chk(16'(len >= 16 && len <= 20), 1);
		wr(`OFS_CONFIG, 8'h02);
		gap();
		gap();
		chk(16'(len >= 192 && len <= 196), 1);
		wr(`OFS_FUNCTION_ENABLE, 8'h05);
		gap();
		gap();
		chk(16'(len <= 3), 1);
		wr(`OFS_CONFIG, 8'h00);
		wr(`OFS_FUNCTION_ENABLE, 8'h01);
		$display("test wait timer done");
		wr(`OFS_PROX_INTEG_TIME, 8'hff);
		for (int i = 0; i < 8; i++)
			interrupt_filter_run(i >= 4, pf[i][3:0], i != 0, pe[i]);
		$display("test persistence done");
		end_sim();
	end
	// Watchdog far beyond the expected run of a few thousand cycles.
	initial begin
		#100000;
		mismatches++;
		end_sim();
	end
endmodule : tb_light_prox_sensor_control
